// *** irq_vec_pkg.sv ***
// constants, register layout and state codes of the interrupt vector and sfr unit
package irq_vec_pkg;
    // sfr byte offsets
    localparam logic [15:0] OFS_EN_LOW = 16'h0000;
    localparam logic [15:0] OFS_EN_HIGH = 16'h0001;
    localparam logic [15:0] OFS_FLAG_LOW = 16'h0002;
    localparam logic [15:0] OFS_FLAG_HIGH = 16'h0003;
    // enable register bit positions
    localparam int EN_WDOG = 0;
    localparam int EN_OSC = 1;
    localparam int EN_PIN = 4;
    localparam int EN_ACCV = 5;
    localparam logic [7:0] EN_IMPL = 8'h33;
    localparam logic [7:0] EN_PUC_VAL = 8'h00;
    // flag register bit positions
    localparam int FL_WDOG = 0;
    localparam int FL_OSC = 1;
    localparam int FL_POR = 2;
    localparam int FL_EXT = 3;
    localparam int FL_PIN = 4;
    localparam logic [7:0] FL_IMPL = 8'h1f;
    localparam logic [7:0] FL_POR_VAL = 8'h06;
    // bits touched by the system clear reset, and their values
    localparam logic [7:0] FL_PUC_MASK = 8'h12;
    localparam logic [7:0] FL_PUC_VAL = 8'h02;
    // vector word addresses
    localparam logic [15:0] VEC_BASE = 16'hffc0;
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_NMI = 16'hfffc;
    localparam logic [15:0] VEC_COMP = 16'hfff6;
    localparam logic [15:0] VEC_WDOG = 16'hfff4;
    localparam logic [15:0] VEC_TCH0 = 16'hfff2;
    localparam logic [15:0] VEC_TCH1 = 16'hfff0;
    localparam logic [15:0] VEC_PORTB = 16'hffe6;
    localparam logic [15:0] VEC_PORTA = 16'hffe4;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    // priorities
    localparam logic [4:0] PRI_RESET = 5'h1f;
    localparam logic [4:0] PRI_NMI = 5'h1e;
    localparam logic [4:0] PRI_COMP = 5'h1b;
    localparam logic [4:0] PRI_WDOG = 5'h1a;
    localparam logic [4:0] PRI_TCH0 = 5'h19;
    localparam logic [4:0] PRI_TCH1 = 5'h18;
    localparam logic [4:0] PRI_PORTB = 5'h13;
    localparam logic [4:0] PRI_PORTA = 5'h12;
    // pending vector index, highest priority at the top
    localparam int PV_RESET = 7;
    localparam int PV_NMI = 6;
    localparam int PV_COMP = 5;
    localparam int PV_WDOG = 4;
    localparam int PV_TCH0 = 3;
    localparam int PV_TCH1 = 2;
    localparam int PV_PORTB = 1;
    localparam int PV_PORTA = 0;
    // register space end and legal fetch ranges
    localparam logic [15:0] SFR_END = 16'h01ff;
    localparam logic [15:0] RAM_LO = 16'h0200;
    localparam logic [15:0] RAM_HI = 16'h027f;
    localparam logic [15:0] INFO_LO = 16'h1000;
    localparam logic [15:0] INFO_HI = 16'h10ff;
    localparam logic [15:0] CODE_LO = 16'hf800;
    // low-power modes
    localparam logic [2:0] MODE_ACTIVE = 3'h0;
    localparam logic [2:0] MODE_DEEPEST = 3'h4;
    typedef enum logic [4:0] {
        ST_BOOT = 5'h01,
        ST_RUN = 5'h02,
        ST_SLEEP = 5'h04,
        ST_WAKE = 5'h08,
        ST_ERASED = 5'h10
    } state_type;
endpackage

// *** irq_vec_if.sv ***
// interfaces between the top and its vector encoder and sfr bank
`timescale 1ns/1ps
interface irq_pend_if;
    logic [7:0] pend;
    logic any;
    logic [15:0] vector;
    logic [4:0] prio;
    modport enc (input pend, output any, vector, prio);
    modport top (output pend, input any, vector, prio);
endinterface

interface sfr_if;
    logic hit;
    logic wr;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic system_clear_reset;
    logic set_wdog;
    logic set_osc;
    logic set_ext;
    logic set_pin;
    logic [7:0] en;
    logic [7:0] flags;
    logic [7:0] rdata;
    modport regs (input hit, wr, addr, wdata, system_clear_reset, set_wdog, set_osc, set_ext, set_pin,
        output en, flags, rdata);
    modport top (output hit, wr, addr, wdata, system_clear_reset, set_wdog, set_osc, set_ext, set_pin,
        input en, flags, rdata);
endinterface

// *** irq_vec_prio.sv ***
// fixed-priority encoder from pending vectors to vector address and priority
`timescale 1ns/1ps
module irq_vec_prio
    import irq_vec_pkg::*;
(
    irq_pend_if.enc pif
);
    // slots 0ffc0h..0ffdeh and the empty ones have no source, so they never appear
    always_comb begin
        pif.any = |pif.pend;
        pif.vector = VEC_PORTA;
        pif.prio = PRI_PORTA;
        if (pif.pend[PV_RESET]) begin
            pif.vector = VEC_RESET;
            pif.prio = PRI_RESET;
        end else if (pif.pend[PV_NMI]) begin
            pif.vector = VEC_NMI;
            pif.prio = PRI_NMI;
        end else if (pif.pend[PV_COMP]) begin
            pif.vector = VEC_COMP;
            pif.prio = PRI_COMP;
        end else if (pif.pend[PV_WDOG]) begin
            pif.vector = VEC_WDOG;
            pif.prio = PRI_WDOG;
        end else if (pif.pend[PV_TCH0]) begin
            pif.vector = VEC_TCH0;
            pif.prio = PRI_TCH0;
        end else if (pif.pend[PV_TCH1]) begin
            pif.vector = VEC_TCH1;
            pif.prio = PRI_TCH1;
        end else if (pif.pend[PV_PORTB]) begin
            pif.vector = VEC_PORTB;
            pif.prio = PRI_PORTB;
        end
    end
endmodule

// *** irq_sfr_regs.sv ***
// enable and system flag registers with power-on and system clear reset values
`timescale 1ns/1ps
module irq_sfr_regs
    import irq_vec_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    sfr_if.regs sif
);
    logic [7:0] en_q, en_d;
    logic [7:0] flags_q, flags_d;
    logic [7:0] rdata_q, rdata_d;

    // next values: write first, then resets, then hardware sets so an event is never lost
    always_comb begin
        en_d = en_q;
        flags_d = flags_q;
        rdata_d = 8'h00;
        if (sif.hit && sif.wr && sif.addr == OFS_EN_LOW[1:0]) begin
            en_d = sif.wdata & EN_IMPL;
        end
        if (sif.hit && sif.wr && sif.addr == OFS_FLAG_LOW[1:0]) begin
            flags_d = sif.wdata & FL_IMPL;
        end
        if (sif.system_clear_reset) begin
            en_d = EN_PUC_VAL;
            flags_d = (flags_d & ~FL_PUC_MASK) | FL_PUC_VAL;
        end
        flags_d[FL_WDOG] = flags_d[FL_WDOG] | sif.set_wdog;
        flags_d[FL_OSC] = flags_d[FL_OSC] | sif.set_osc;
        flags_d[FL_EXT] = flags_d[FL_EXT] | sif.set_ext;
        flags_d[FL_PIN] = flags_d[FL_PIN] | sif.set_pin;
        // unimplemented bits and the high bytes read as zero
        if (sif.hit && sif.addr == OFS_EN_LOW[1:0]) begin
            rdata_d = en_q;
        end else if (sif.hit && sif.addr == OFS_FLAG_LOW[1:0]) begin
            rdata_d = flags_q;
        end
    end

    // power-on reset loads every bit, including those the system clear leaves alone
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            en_q <= EN_PUC_VAL;
            flags_q <= FL_POR_VAL;
            rdata_q <= 8'h00;
        end else begin
            en_q <= en_d;
            flags_q <= flags_d;
            rdata_q <= rdata_d;
        end
    end

    assign sif.en = en_q;
    assign sif.flags = flags_q;
    assign sif.rdata = rdata_q;
endmodule

// *** irq_vector_sfr_unit.sv ***
// interrupt and reset vector unit with low special function registers
// Operation
// - vectors and start address lie in ffc0h-ffffh
// - each vector holds a 16-bit handler address
// - erased reset vector at power-up sends device to deepest sleep
// - all reset sources use fffeh, priority 31
// - fetch from registers or unused space resets
// - pin, oscillator, flash violation share fffch, 30
// - own enables gate these; global enable does not
// - fixed maskable vectors; highest priority served first
// - port b flags share ffe6h, priority 19
// - port a flags share ffe4h, priority 18
// - slots ffc0h-ffdeh carry no interrupt source
// - module request flags stay inside their modules
// - unassigned register bits absent, read zero
// - plain reset values applied by system clear
// - bracketed reset values applied by power-on only
// - enable register bits 0,1,4,5; 01h empty
// - flag register bits 0-4; 03h empty
// - oscillator fault sets flag; system clear sets too
// - power-on flag set on power-up only
// - external reset flag set by pin reset
// - pin request flag set by pin event
// - interrupt wakes, handler runs, sleep resumes after
// - deepest sleep stops cpu, clocks, dc generator, crystal
// - watchdog interval enable ignored in reset mode
`timescale 1ns/1ps
module irq_vector_sfr_unit
    import irq_vec_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    output logic [7:0] cpu_rdata,
    input wire logic fetch_valid,
    input wire logic [15:0] fetch_addr,
    input wire logic cpu_gie,
    input wire logic [2:0] cpu_sleep_mode,
    input wire logic cpu_reti,
    output logic irq_req,
    output logic [15:0] irq_vector,
    output logic [4:0] irq_prio,
    input wire logic irq_ack,
    input wire logic [15:0] irq_word,
    output logic [15:0] handler_addr,
    output logic sys_clear_reset,
    output logic deepest_sleep_state,
    output logic cpu_clk_en,
    output logic mclk_en,
    output logic smclk_en,
    output logic aclk_en,
    output logic dcgen_en,
    output logic xtal_en,
    input wire logic ext_reset_evt,
    input wire logic wdog_expiry,
    input wire logic flash_key_viol_flag,
    input wire logic nmi_pin_evt,
    input wire logic osc_fault,
    input wire logic flash_access_viol_flag,
    input wire logic wdog_interval_evt,
    input wire logic wdog_interval_mode,
    input wire logic comparator_event_flag,
    input wire logic timer_ch0_flag,
    input wire logic timer_ch1_flag,
    input wire logic timer_overflow_flag,
    input wire logic [7:0] port_a_pin_flags,
    input wire logic [1:0] port_b_pin_flags
);
    // fetch is legal only from ram, information memory or code flash
    function automatic logic fetch_illegal(input logic [15:0] a);
        logic ok;
        ok = (a >= RAM_LO && a <= RAM_HI) || (a >= INFO_LO && a <= INFO_HI) || (a >= CODE_LO);
        fetch_illegal = !ok || (a <= SFR_END);
    endfunction

    // clock enables {cpu, mclk, smclk, aclk, dcgen, xtal} for a sleep depth
    function automatic logic [5:0] lpm_clocks(input logic [2:0] m);
        logic [5:0] c;
        c = 6'h3f;
        // mode 1 keeps the dc generator running so wake-up from it stays quick
        unique case (m)
            3'h0: c = 6'h3f;
            3'h1: c = 6'h0f;
            3'h2: c = 6'h07;
            3'h3: c = 6'h05;
            default: c = 6'h00;
        endcase
        lpm_clocks = c;
    endfunction

    irq_pend_if pif();
    sfr_if sif();

    irq_vec_prio u_prio (
        .pif(pif)
    );

    irq_sfr_regs u_sfr (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .sif(sif)
    );

    state_type state_q, state_d;
    logic [2:0] mode_q, mode_d;
    logic por_boot_q, por_boot_d;
    logic puc_q, puc_d;
    logic [15:0] handler_q, handler_d;
    logic [5:0] clk_q, clk_d;
    logic [2:0] mode_eff;
    logic nmi_pend;
    logic wdog_pend;

    // register bus: byte registers at 00h..03h, everything else ignored here
    always_comb begin
        sif.hit = (cpu_wr || cpu_rd) && cpu_addr[15:2] == OFS_EN_LOW[15:2];
        sif.wr = cpu_wr;
        sif.addr = cpu_addr[1:0];
        sif.wdata = cpu_wdata;
        sif.system_clear_reset = puc_q;
        sif.set_wdog = wdog_expiry || flash_key_viol_flag || wdog_interval_evt;
        sif.set_osc = osc_fault;
        sif.set_ext = ext_reset_evt;
        sif.set_pin = nmi_pin_evt;
    end
    assign cpu_rdata = sif.rdata;

    // pending sources; module-owned flags arrive as levels and are not stored here
    always_comb begin
        nmi_pend = (sif.flags[FL_PIN] && sif.en[EN_PIN])
            || (sif.flags[FL_OSC] && sif.en[EN_OSC])
            || (flash_access_viol_flag && sif.en[EN_ACCV]);
        // the interval enable only counts when the watchdog is an interval timer
        wdog_pend = sif.flags[FL_WDOG] && sif.en[EN_WDOG] && wdog_interval_mode;
        pif.pend = 8'h00;
        pif.pend[PV_RESET] = state_q == ST_BOOT;
        pif.pend[PV_NMI] = nmi_pend;
        pif.pend[PV_COMP] = comparator_event_flag;
        pif.pend[PV_WDOG] = wdog_pend;
        pif.pend[PV_TCH0] = timer_ch0_flag;
        pif.pend[PV_TCH1] = timer_ch1_flag || timer_overflow_flag;
        pif.pend[PV_PORTB] = |port_b_pin_flags;
        pif.pend[PV_PORTA] = |port_a_pin_flags;
    end

    // request to the cpu; maskable vectors wait for the global enable
    always_comb begin
        irq_vector = pif.vector;
        irq_prio = pif.prio;
        unique case (state_q)
            ST_BOOT: irq_req = 1'b1;
            ST_ERASED: irq_req = 1'b0;
            default: irq_req = pif.any && (nmi_pend || cpu_gie);
        endcase
    end

    // system clear reset: every reset source but power-on, registered, high as long as its source
    always_comb begin
        puc_d = ext_reset_evt || wdog_expiry || flash_key_viol_flag;
        puc_d = puc_d || (fetch_valid && fetch_illegal(fetch_addr));
    end

    // sequencer: boot vector, run, sleep, handler woken from sleep, erased lock
    always_comb begin
        state_d = state_q;
        mode_d = mode_q;
        por_boot_d = por_boot_q;
        handler_d = handler_q;
        if (irq_ack && irq_req) begin
            handler_d = irq_word;
        end
        unique case (state_q)
            ST_BOOT: begin
                if (irq_ack) begin
                    por_boot_d = 1'b0;
                    // only a power-up boot checks for unprogrammed flash
                    if (por_boot_q && irq_word == ERASED_WORD) begin
                        state_d = ST_ERASED;
                    end else begin
                        state_d = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (!(irq_ack && irq_req) && cpu_sleep_mode != MODE_ACTIVE) begin
                    state_d = ST_SLEEP;
                    mode_d = cpu_sleep_mode > MODE_DEEPEST ? MODE_DEEPEST : cpu_sleep_mode;
                end
            end
            ST_SLEEP: begin
                if (irq_ack && irq_req) begin
                    state_d = ST_WAKE;
                end
            end
            ST_WAKE: begin
                // a nested handler's return also resumes sleep; no nesting depth is kept
                if (cpu_reti) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_ERASED: begin
                state_d = ST_ERASED;
            end
        endcase
        if (puc_q) begin
            state_d = ST_BOOT;
        end
    end

    // a sleeping device with an accepted-to-be request gets its clocks back
    always_comb begin
        if (state_q == ST_ERASED) begin
            mode_eff = MODE_DEEPEST;
        end else if (state_q == ST_SLEEP && !irq_req) begin
            mode_eff = mode_q;
        end else begin
            mode_eff = MODE_ACTIVE;
        end
        clk_d = lpm_clocks(mode_eff);
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_q <= ST_BOOT;
            mode_q <= MODE_ACTIVE;
            por_boot_q <= 1'b1;
            puc_q <= 1'b0;
            handler_q <= 16'h0000;
            clk_q <= 6'h3f;
        end else begin
            state_q <= state_d;
            mode_q <= mode_d;
            por_boot_q <= por_boot_d;
            puc_q <= puc_d;
            handler_q <= handler_d;
            clk_q <= clk_d;
        end
    end

    assign sys_clear_reset = puc_q;
    assign handler_addr = handler_q;
    assign deepest_sleep_state = state_q == ST_ERASED;
    assign cpu_clk_en = clk_q[5];
    assign mclk_en = clk_q[4];
    assign smclk_en = clk_q[3];
    assign aclk_en = clk_q[2];
    assign dcgen_en = clk_q[1];
    assign xtal_en = clk_q[0];

    // checks
    a_vec_range: assert property (@(posedge ref_clk) disable iff (!nrst)
        irq_req |-> irq_vector >= VEC_BASE) else $error("vector below range");
    a_boot_vector: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == ST_BOOT |-> irq_req && irq_vector == VEC_RESET && irq_prio == PRI_RESET)
        else $error("boot not on reset vector");
    a_erased_lock: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == ST_BOOT && por_boot_q && irq_ack && irq_word == ERASED_WORD && !puc_q
        |=> deepest_sleep_state ##1 !cpu_clk_en && !xtal_en && !aclk_en)
        else $error("erased vector did not stop device");
    a_fetch_reset: assert property (@(posedge ref_clk) disable iff (!nrst)
        fetch_valid && fetch_addr <= SFR_END |=> sys_clear_reset ##1 state_q == ST_BOOT)
        else $error("bad fetch gave no reset");
    a_nmi_no_gie: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == ST_RUN && !cpu_gie && nmi_pend |-> irq_req && irq_vector == VEC_NMI)
        else $error("nmi blocked by global enable");
    a_gie_masks: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == ST_RUN && !cpu_gie && !nmi_pend |-> !irq_req)
        else $error("maskable request without global enable");
    a_wdog_mode: assert property (@(posedge ref_clk) disable iff (!nrst)
        irq_req && !wdog_interval_mode |-> irq_vector != VEC_WDOG)
        else $error("watchdog vector in reset mode");
    a_pin_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
        nmi_pin_evt |=> sif.flags[FL_PIN]) else $error("pin flag not set");
    a_ext_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
        ext_reset_evt |=> sif.flags[FL_EXT]) else $error("external reset flag not set");
    a_osc_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
        osc_fault |=> sif.flags[FL_OSC]) else $error("oscillator fault flag not set");
    a_handler_load: assert property (@(posedge ref_clk) disable iff (!nrst)
        irq_ack && irq_req |=> handler_addr == $past(irq_word)) else $error("handler not loaded");
    a_puc_values: assert property (@(posedge ref_clk) disable iff (!nrst)
        sys_clear_reset && !cpu_wr && !ext_reset_evt
        |=> sif.en == EN_PUC_VAL && sif.flags[FL_OSC]
            && sif.flags[FL_POR] == $past(sif.flags[FL_POR])
            && sif.flags[FL_EXT] == $past(sif.flags[FL_EXT]))
        else $error("system clear values wrong");
    a_wake_return: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_q == ST_WAKE && cpu_reti && !puc_q
        |=> state_q == ST_SLEEP ##1 mode_q == $past(mode_q, 2))
        else $error("no return to sleep");
    // main scenarios reached
    c_boot_run: cover property (@(posedge ref_clk) disable iff (!nrst)
        state_q == ST_BOOT ##1 state_q == ST_RUN);
    c_sleep_wake: cover property (@(posedge ref_clk) disable iff (!nrst)
        state_q == ST_SLEEP ##1 state_q == ST_WAKE);
    c_nmi_taken: cover property (@(posedge ref_clk) disable iff (!nrst)
        irq_ack && irq_vector == VEC_NMI);
    c_erased_boot: cover property (@(posedge ref_clk) disable iff (!nrst)
        state_q == ST_BOOT ##1 deepest_sleep_state);
    c_clear_boot: cover property (@(posedge ref_clk) disable iff (!nrst)
        sys_clear_reset ##1 state_q == ST_BOOT);
endmodule

// *** cpu_vec_model.sv ***
// cpu-side model of the vector handshake: reads the vector word table and accepts requests
`timescale 1ns/1ps
module cpu_vec_model (
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic ack_cmd,
    input wire logic [15:0] reset_word,
    output logic irq_ack,
    output logic [15:0] irq_word
);
    // reset slot word comes from the bench so that an erased part can be mimicked
    always_comb begin
        if (irq_vector == 16'hfffe) begin
            irq_word = reset_word;
        end else begin
            irq_word = {8'hf8, irq_vector[7:0]};
        end
    end
    // a real core only accepts while a request stands, so the bench cannot ack into nothing
    assign irq_ack = ack_cmd & irq_req;
endmodule

// *** testbench.sv ***
// self-checking bench for the interrupt vector and special function register unit
`timescale 1ns/1ps
module testbench
    import irq_vec_pkg::*;
;
    logic ref_clk = 0, nrst = 0, cpu_wr = 0, cpu_rd = 0, fetch_valid = 0, cpu_gie = 0;
    logic cpu_reti = 0, ext_reset_evt = 0, wdog_expiry = 0, flash_key_viol_flag = 0;
    logic nmi_pin_evt = 0, osc_fault = 0, flash_access_viol_flag = 0, wdog_interval_evt = 0;
    logic wdog_interval_mode = 0, comparator_event_flag = 0, timer_ch0_flag = 0;
    logic timer_ch1_flag = 0, timer_overflow_flag = 0, ack_cmd = 0, irq_req, irq_ack;
    logic sys_clear_reset, deepest_sleep_state, cpu_clk_en, mclk_en, smclk_en, aclk_en;
    logic dcgen_en, xtal_en, seen;
    logic [15:0] cpu_addr = 16'h0000, fetch_addr = 16'hf800, irq_word, irq_vector, handler_addr;
    logic [15:0] reset_word = 16'hf800;
    logic [7:0] cpu_wdata = 8'h00, port_a_pin_flags = 8'h00, cpu_rdata;
    logic [4:0] irq_prio;
    logic [2:0] cpu_sleep_mode = 3'h0;
    logic [1:0] port_b_pin_flags = 2'h0;
    logic [15:0] fa [4] = '{16'h01ff, 16'h0200, 16'h0300, 16'h1000};
    int err_count = 0, total_checks = 0;
    wire [5:0] clk_ens = {cpu_clk_en, mclk_en, smclk_en, aclk_en, dcgen_en, xtal_en};

    always #10 ref_clk = ~ref_clk;

    irq_vector_sfr_unit dut (
        .ref_clk, .nrst, .cpu_addr, .cpu_wdata, .cpu_wr, .cpu_rd, .cpu_rdata, .fetch_valid,
        .fetch_addr, .cpu_gie, .cpu_sleep_mode, .cpu_reti, .irq_req, .irq_vector, .irq_prio,
        .irq_ack, .irq_word, .handler_addr, .sys_clear_reset, .deepest_sleep_state,
        .cpu_clk_en, .mclk_en, .smclk_en, .aclk_en, .dcgen_en, .xtal_en, .ext_reset_evt,
        .wdog_expiry, .flash_key_viol_flag, .nmi_pin_evt, .osc_fault, .flash_access_viol_flag,
        .wdog_interval_evt, .wdog_interval_mode, .comparator_event_flag, .timer_ch0_flag,
        .timer_ch1_flag, .timer_overflow_flag, .port_a_pin_flags, .port_b_pin_flags
    );
    cpu_vec_model cpu (.irq_req, .irq_vector, .ack_cmd, .reset_word, .irq_ack, .irq_word);

    // one comparison kind for every result, widened to a common width
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    // leading idle cycle keeps a strobe from being dropped and raised in one time step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cyc(1);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1;
        cyc(1);
        cpu_wr = 0;
    endtask
    // read data stands only in the cycle after the strobe edge
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        cyc(1);
        cpu_addr = a;
        cpu_rd = 1;
        cyc(1);
        cpu_rd = 0;
        chk(cpu_rdata, e);
    endtask
    task automatic req_chk(input logic [15:0] v, input logic [4:0] p);
        chk({irq_req, irq_vector, irq_prio}, {1'b1, v, p});
    endtask
    task automatic acc(input logic [15:0] e);
        cyc(1);
        ack_cmd = 1;
        cyc(1);
        ack_cmd = 0;
        chk(handler_addr, e);
    endtask
    task automatic por();
        nrst = 0;
        cyc(3);
        nrst = 1;
    endtask

    task automatic t_boot();
        por();
        req_chk(VEC_RESET, PRI_RESET);
        rd_chk(OFS_FLAG_LOW, 8'h06);
        rd_chk(OFS_EN_LOW, 8'h00);
        acc(16'hf800);
        done("boot");
    endtask
    // unimplemented bits and empty registers ignore writes and read as zero
    task automatic t_regs();
        wr(OFS_EN_LOW, 8'hff);
        wr(OFS_EN_HIGH, 8'hff);
        wr(OFS_FLAG_HIGH, 8'hff);
        rd_chk(OFS_EN_LOW, 8'h33);
        rd_chk(OFS_EN_HIGH, 8'h00);
        rd_chk(OFS_FLAG_HIGH, 8'h00);
        wr(OFS_FLAG_LOW, 8'hff);
        rd_chk(OFS_FLAG_LOW, 8'h1f);
        req_chk(VEC_NMI, PRI_NMI);
        wr(OFS_EN_LOW, 8'h00);
        wr(OFS_FLAG_LOW, 8'h00);
        cyc(1);
        chk(irq_req, 1'b0);
        done("regs");
    endtask
    task automatic t_nmi();
        nmi_pin_evt = 1;
        cyc(1);
        nmi_pin_evt = 0;
        rd_chk(OFS_FLAG_LOW, 8'h10);
        chk(irq_req, 1'b0);
        wr(OFS_EN_LOW, 8'h10);
        cyc(1);
        req_chk(VEC_NMI, PRI_NMI);
        wr(OFS_EN_LOW, 8'h02);
        wr(OFS_FLAG_LOW, 8'h00);
        osc_fault = 1;
        cyc(1);
        osc_fault = 0;
        rd_chk(OFS_FLAG_LOW, 8'h02);
        req_chk(VEC_NMI, PRI_NMI);
        wr(OFS_EN_LOW, 8'h20);
        wr(OFS_FLAG_LOW, 8'h00);
        chk(irq_req, 1'b0);
        flash_access_viol_flag = 1;
        cyc(1);
        req_chk(VEC_NMI, PRI_NMI);
        flash_access_viol_flag = 0;
        wr(OFS_EN_LOW, 8'h00);
        done("nmi");
    endtask
    // requests are peeled off from the top so each priority step is seen
    task automatic t_mask();
        cpu_gie = 1;
        {comparator_event_flag, timer_ch0_flag, timer_ch1_flag} = 3'h7;
        port_b_pin_flags = 2'h2;
        port_a_pin_flags = 8'h80;
        cyc(1);
        req_chk(VEC_COMP, PRI_COMP);
        rd_chk(OFS_FLAG_LOW, 8'h00);
        comparator_event_flag = 0;
        wr(OFS_EN_LOW, 8'h01);
        wdog_interval_evt = 1;
        cyc(1);
        wdog_interval_evt = 0;
        req_chk(VEC_TCH0, PRI_TCH0);
        wdog_interval_mode = 1;
        cyc(1);
        req_chk(VEC_WDOG, PRI_WDOG);
        wr(OFS_FLAG_LOW, 8'h00);
        timer_ch0_flag = 0;
        cyc(1);
        req_chk(VEC_TCH1, PRI_TCH1);
        timer_ch1_flag = 0;
        timer_overflow_flag = 1;
        cyc(1);
        req_chk(VEC_TCH1, PRI_TCH1);
        timer_overflow_flag = 0;
        cyc(1);
        req_chk(VEC_PORTB, PRI_PORTB);
        port_b_pin_flags = 2'h0;
        cyc(1);
        req_chk(VEC_PORTA, PRI_PORTA);
        cpu_gie = 0;
        cyc(1);
        chk(irq_req, 1'b0);
        port_a_pin_flags = 8'h00;
        done("mask");
    endtask
    // boundary fetches around the register space and an unused hole
    task automatic t_fetch();
        for (int i = 0; i < 4; i++) begin
            wr(OFS_EN_LOW, 8'h01);
            cyc(1);
            fetch_addr = fa[i];
            fetch_valid = 1;
            seen = 0;
            for (int k = 0; k < 4; k++) begin
                cyc(1);
                fetch_valid = 0;
                seen = seen | sys_clear_reset;
            end
            chk(seen, (i % 2 == 0));
            if (i % 2 == 0) begin
                req_chk(VEC_RESET, PRI_RESET);
                rd_chk(OFS_EN_LOW, 8'h00);
                rd_chk(OFS_FLAG_LOW, 8'h02);
                acc(16'hf800);
            end
        end
        done("fetch");
    endtask
    // pin reset, then watchdog expiry: each runs a system clear and keeps its flag
    task automatic t_resets();
        ext_reset_evt = 1;
        cyc(1);
        ext_reset_evt = 0;
        cyc(1);
        req_chk(VEC_RESET, PRI_RESET);
        rd_chk(OFS_FLAG_LOW, 8'h0a);
        acc(16'hf800);
        wdog_expiry = 1;
        cyc(1);
        wdog_expiry = 0;
        cyc(1);
        req_chk(VEC_RESET, PRI_RESET);
        rd_chk(OFS_FLAG_LOW, 8'h0b);
        acc(16'hf800);
        done("resets");
    endtask
    task automatic t_erased();
        reset_word = ERASED_WORD;
        por();
        acc(ERASED_WORD);
        cyc(2);
        chk({deepest_sleep_state, irq_req}, 2'h2);
        chk(clk_ens, 6'h00);
        reset_word = 16'hf800;
        done("erased");
    endtask
    task automatic t_sleep();
        por();
        acc(16'hf800);
        cpu_sleep_mode = 3'h3;
        cyc(2);
        chk(clk_ens, 6'h05);
        cpu_gie = 1;
        timer_ch0_flag = 1;
        cyc(2);
        chk(clk_ens, 6'h3f);
        acc(16'hf8f2);
        timer_ch0_flag = 0;
        cpu_reti = 1;
        cyc(1);
        cpu_reti = 0;
        cyc(1);
        chk(clk_ens, 6'h05);
        done("sleep");
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // the run needs under 150 cycles; this bound only catches a hang
    initial begin
        #100000;
        err_count++;
        summarize();
    end
    initial begin
        t_boot();
        t_regs();
        t_nmi();
        t_mask();
        t_fetch();
        t_resets();
        t_erased();
        t_sleep();
        summarize();
    end
endmodule
